// ---- rtl/cfg_link_if.sv ----
// Interface carrying the synchronised link levels between the loader modules
`timescale 1ns/1ns
interface cfg_link_if;
  logic chip_sel;
  logic status_in;
  logic bitclk_in;
  modport sync_side
  (
    output chip_sel,
    output status_in,
    output bitclk_in
  );
  modport core_side
  (
    input chip_sel,
    input status_in,
    input bitclk_in
  );
endinterface

// ---- rtl/cfg_loader.sv ----
// Power-on, master/slave selection and error supervision of a serial config memory
// Function
// R1: Hold off configuration for power-on delay
// R2: Pull status pin low during power-on delay
// R3: Release status pin when delay ends
// R4: Chip-select high at exit gives slave mode
// R5: Target powered before delay ends
// R6: Early done as master flags error
// R7: No done 16 clocks after end flags error
// R8: Auto-restart after error when enabled
// R9: Target pulls status low on CRC error
// R10: External status low resets configuration state
// R11: Status low clears counter, tri-states data
// R12: Chip-select low after reset enables output
// R13: Master drives bit clock, cascade low after data
// R14: Idle with bit clock low after done
// R15: Delay and done wait counted by timers
`timescale 1ns/1ns
module cfg_loader
  import cfg_loader_pkg::*;
#(
  parameter int POR_COUNT = POR_CYCLES,
  parameter int BITS = STREAM_BITS,
  parameter int DONE_WAIT = DONE_WAIT_CLOCKS
)
(
  input wire logic CLOCK,
  input wire logic RST,
  input wire logic CHIP_SEL_N,
  input wire logic TARGET_STATUS_LOW_IN,
  output logic TARGET_STATUS_LOW_OUT,
  output logic TARGET_STATUS_LOW_OE,
  input wire logic BITCLK_IN,
  output logic BITCLK_OUT,
  output logic BITCLK_OE,
  output logic DATA_OUT,
  output logic DATA_OE,
  output logic CASCADE_N,
  input wire logic AUTO_RESTART,
  input wire logic MEM_BIT,
  output logic [ADDR_W-1:0] MEM_ADDR,
  output logic SLAVE_MODE,
  output logic CONFIG_ERROR,
  output logic CONFIG_DONE
);
  typedef enum {ST_POR, ST_WAIT_REL, ST_SELECT, ST_SEND, ST_DONE_WAIT, ST_ERROR,
    ST_IDLE, ST_SLAVE} state_e;

  // Refuse sizes that the counters cannot hold; the address must reach BITS
  if (POR_COUNT < 1 || BITS < 1 || DONE_WAIT < 1 || DONE_WAIT > 255 ||
    BITS >= (1 << ADDR_W))
  begin : g_bad_params
    $error("cfg_loader: unusable parameter values");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Synchronised pins
  cfg_link_if link ();

  cfg_pin_sync i_cfg_pin_sync
  (
    .CLOCK(CLOCK),
    .RST(RST),
    .chip_sel_pin(CHIP_SEL_N),
    .status_pin(TARGET_STATUS_LOW_IN),
    .bitclk_pin(BITCLK_IN),
    .link(link.sync_side)
  );

  ////////////////////////////////////////////////////////////////////////////
  // State and counters
  state_e state_reg, state_next;
  logic [31:0] timer_reg, timer_next;
  logic [ADDR_W-1:0] addr_reg, addr_next;
  logic [7:0] div_reg, div_next;
  logic bitclk_reg, bitclk_next;
  logic data_reg, data_next;
  logic [7:0] wait_reg, wait_next;
  logic error_reg, error_next;

  // Wire decode; a pin driven low by us also reads low, so only outside lows count
  wire driving_low = (state_reg == ST_POR) || (state_reg == ST_ERROR);
  wire ext_status_low = !link.status_in && !driving_low;
  wire done_high = link.chip_sel;
  wire half_tick = (div_reg == 8'(BITCLK_HALF - 1));
  wire fall_tick = half_tick && bitclk_reg;
  // The counter points at the next bit to fetch, so the memory read has a cycle
  wire all_sent = (addr_reg == ADDR_W'(BITS));

  function automatic logic [31:0] dec_sat(input logic [31:0] v);
    dec_sat = (v == 32'h0000_0000) ? v : v - 32'h0000_0001;
  endfunction

  function automatic logic [ADDR_W-1:0] addr_inc(input logic [ADDR_W-1:0] a);
    addr_inc = a + ADDR_W'(1);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic
  always_comb
  begin
    state_next = state_reg;
    timer_next = timer_reg;
    addr_next = addr_reg;
    div_next = half_tick ? 8'h00 : div_reg + 8'h01;
    bitclk_next = bitclk_reg;
    data_next = data_reg;
    wait_next = wait_reg;
    error_next = error_reg;
    case (state_reg)
      ST_POR:
      begin
        timer_next = dec_sat(timer_reg); // [R15]
        if (timer_reg == 32'h0000_0000)
          state_next = ST_WAIT_REL; // [R1] [R3]
      end
      ST_WAIT_REL:
      begin
        // Pull-up needs time to raise the released line
        if (link.status_in)
          state_next = ST_SELECT;
      end
      ST_SELECT:
      begin
        addr_next = ADDR_RESET; // [R11]
        bitclk_next = 1'b0;
        div_next = 8'h00;
        if (done_high)
          state_next = ST_SLAVE; // [R4] [R12]
        else
        begin
          state_next = ST_SEND; // [R12]
          data_next = MEM_BIT;
          addr_next = addr_inc(ADDR_RESET);
        end
      end
      ST_SEND:
      begin
        if (half_tick)
          bitclk_next = !bitclk_reg; // [R13]
        if (done_high)
        begin
          state_next = ST_ERROR; // [R6]
          error_next = 1'b1;
          timer_next = 32'h0000_0003;
        end
        else if (fall_tick)
        begin
          if (all_sent)
          begin
            state_next = ST_DONE_WAIT;
            wait_next = 8'(DONE_WAIT); // [R7]
          end
          else
          begin
            addr_next = addr_inc(addr_reg);
            data_next = MEM_BIT;
          end
        end
      end
      ST_DONE_WAIT:
      begin
        if (half_tick)
          bitclk_next = !bitclk_reg; // [R13]
        if (done_high)
        begin
          state_next = ST_IDLE; // [R14]
          bitclk_next = 1'b0;
        end
        else if (fall_tick)
        begin
          wait_next = wait_reg - 8'h01; // [R15]
          if (wait_reg == 8'h01)
          begin
            state_next = ST_ERROR; // [R7]
            error_next = 1'b1;
            timer_next = 32'h0000_0003;
          end
        end
      end
      ST_ERROR:
      begin
        // Status pin low: a short pulse then restart, or held low while we stay
        bitclk_next = 1'b0;
        addr_next = ADDR_RESET; // [R11]
        timer_next = dec_sat(timer_reg);
        if (timer_reg == 32'h0000_0000 && AUTO_RESTART)
          state_next = ST_WAIT_REL; // [R8]
      end
      ST_IDLE:
        bitclk_next = 1'b0; // [R14]
      ST_SLAVE:
        bitclk_next = 1'b0;
      default:
        state_next = ST_POR;
    endcase
    // Target pulling status low resets state, address, bit clock and error after power-on
    if (ext_status_low && state_reg != ST_WAIT_REL && state_reg != ST_POR)
    begin
      // A fresh error in the same cycle wins over the clear
      if (state_next != ST_ERROR)
        error_next = 1'b0;
      state_next = ST_WAIT_REL; // [R10] [R9]
      addr_next = ADDR_RESET; // [R11]
      bitclk_next = 1'b0;
    end
    if (state_next == ST_SEND && state_reg == ST_SELECT)
      error_next = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  always_ff @(posedge CLOCK or posedge RST)
  begin
    if (RST)
    begin
      state_reg <= ST_POR;
      timer_reg <= 32'(POR_COUNT - 1);
      addr_reg <= ADDR_RESET;
      div_reg <= 8'h00;
      bitclk_reg <= 1'b0;
      data_reg <= 1'b0;
      wait_reg <= 8'h00;
      error_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      timer_reg <= timer_next;
      addr_reg <= addr_next;
      div_reg <= div_next;
      bitclk_reg <= bitclk_next;
      data_reg <= data_next;
      wait_reg <= wait_next;
      error_reg <= error_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin drive; open-drain status only ever drives low
  assign TARGET_STATUS_LOW_OUT = 1'b0;
  assign TARGET_STATUS_LOW_OE = driving_low; // [R2] [R6] [R7]
  wire sending = (state_reg == ST_SEND);
  wire mastering = sending || (state_reg == ST_DONE_WAIT);
  assign BITCLK_OUT = bitclk_reg;
  assign BITCLK_OE = mastering || (state_reg == ST_IDLE); // [R13] [R14]
  assign DATA_OUT = data_reg;
  assign DATA_OE = sending; // [R11] [R12]
  assign CASCADE_N = !(state_reg == ST_DONE_WAIT || state_reg == ST_IDLE); // [R13]
  assign MEM_ADDR = addr_reg;
  assign SLAVE_MODE = (state_reg == ST_SLAVE); // [R4]
  assign CONFIG_ERROR = error_reg;
  assign CONFIG_DONE = (state_reg == ST_IDLE);
endmodule

// ---- rtl/cfg_loader_pkg.sv ----
// Constants shared by the configuration loader supervisor
package cfg_loader_pkg;
  // System clock rate
  localparam int CLK_HZ = 100_000_000;
  // Power-on delay, longest time, in microseconds
  localparam int POR_DELAY_US = 200_000;
  // Cycles of the power-on delay; a longest time rounds down
  localparam int POR_CYCLES = (POR_DELAY_US / 1000) * (CLK_HZ / 1000);
  // Bit clocks waited for done after the last bit
  localparam int DONE_WAIT_CLOCKS = 16;
  // Bit clock divider: half period in system cycles
  localparam int BITCLK_HALF = 4;
  // Default bitstream length in bits
  localparam int STREAM_BITS = 1024;
  // Address counter width
  localparam int ADDR_W = 24;
  localparam logic [ADDR_W-1:0] ADDR_RESET = 24'h00_0000;
endpackage

// ---- rtl/cfg_pin_sync.sv ----
// Two-stage synchronisers for the pins that come from outside the clock domain
`timescale 1ns/1ns
module cfg_pin_sync
(
  input wire logic CLOCK,
  input wire logic RST,
  input wire logic chip_sel_pin,
  input wire logic status_pin,
  input wire logic bitclk_pin,
  cfg_link_if.sync_side link
);
  logic [2:0] stage1_reg;
  logic [2:0] stage2_reg;

  // First stage feeds only the second; status resets low since we hold it low
  // in reset, so a stale high cannot end the wait for the pull-up early
  always_ff @(posedge CLOCK or posedge RST)
  begin
    if (RST)
    begin
      stage1_reg <= 3'h5;
      stage2_reg <= 3'h5;
    end
    else
    begin
      stage1_reg <= {bitclk_pin, status_pin, chip_sel_pin};
      stage2_reg <= stage1_reg;
    end
  end

  assign link.chip_sel = stage2_reg[0];
  assign link.status_in = stage2_reg[1];
  assign link.bitclk_in = stage2_reg[2];
endmodule

// ---- verification/cfg_loader_checker.sv ----
// Pin-level assertions for the configuration loader supervisor
`timescale 1ns/1ns
module cfg_loader_checker
  import cfg_loader_pkg::*;
#(
  parameter int POR_COUNT = POR_CYCLES
)
(
  input wire logic CLOCK,
  input wire logic RST,
  input wire logic CHIP_SEL_N,
  input wire logic TARGET_STATUS_LOW_IN,
  input wire logic TARGET_STATUS_LOW_OE,
  input wire logic BITCLK_OUT,
  input wire logic BITCLK_OE,
  input wire logic DATA_OE,
  input wire logic CASCADE_N,
  input wire logic [ADDR_W-1:0] MEM_ADDR,
  input wire logic SLAVE_MODE,
  input wire logic CONFIG_ERROR,
  input wire logic CONFIG_DONE
);
  int c;
  default clocking @(posedge CLOCK); endclocking
  default disable iff (RST);
  // Cycles since reset; saturates so the release check fires once
  always_ff @(posedge CLOCK or posedge RST)
    if (RST)
      c <= 0;
    else if (c < POR_COUNT + 8)
      c <= c + 1;
  ////////////////////////////////////////
  property p_hold; c < POR_COUNT |-> TARGET_STATUS_LOW_OE; endproperty
  a_hold: assert property (p_hold) else $error("early release");
  property p_rel; c == POR_COUNT + 4 |-> !TARGET_STATUS_LOW_OE; endproperty
  a_rel: assert property (p_rel) else $error("no release");
  property p_slave; SLAVE_MODE |-> !DATA_OE && !BITCLK_OE; endproperty
  a_slave: assert property (p_slave) else $error("slave drives");
  property p_early;
    $rose(CHIP_SEL_N) && DATA_OE |-> ##[1:6] CONFIG_ERROR && TARGET_STATUS_LOW_OE;
  endproperty
  a_early: assert property (p_early) else $error("early done missed");
  // Window around 16 bit clocks of 8 cycles each
  property p_late;
    $fell(DATA_OE) ##1 !CASCADE_N |-> ##[123:133] (CONFIG_ERROR || CONFIG_DONE);
  endproperty
  a_late: assert property (p_late) else $error("late done missed");
  property p_casc; DATA_OE |-> CASCADE_N && BITCLK_OE; endproperty
  a_casc: assert property (p_casc) else $error("cascade");
  property p_idle;
    CONFIG_DONE |-> !BITCLK_OUT && !DATA_OE && !TARGET_STATUS_LOW_OE;
  endproperty
  a_idle: assert property (p_idle) else $error("idle");
  property p_clr;
    $rose(TARGET_STATUS_LOW_OE) |-> ##[0:4] (MEM_ADDR == ADDR_RESET && !DATA_OE);
  endproperty
  a_clr: assert property (p_clr) else $error("no clear");
  property p_ext;
    !TARGET_STATUS_LOW_IN && !TARGET_STATUS_LOW_OE && DATA_OE |-> ##[1:6] !DATA_OE;
  endproperty
  a_ext: assert property (p_ext) else $error("no outside reset");
  c_done: cover property ($rose(CONFIG_DONE));
  c_slave: cover property ($rose(SLAVE_MODE));
  c_err: cover property ($rose(CONFIG_ERROR));
endmodule
bind cfg_loader cfg_loader_checker #(.POR_COUNT(POR_COUNT)) i_cfg_loader_checker
(
  .CLOCK(CLOCK),
  .RST(RST),
  .CHIP_SEL_N(CHIP_SEL_N),
  .TARGET_STATUS_LOW_IN(TARGET_STATUS_LOW_IN),
  .TARGET_STATUS_LOW_OE(TARGET_STATUS_LOW_OE),
  .BITCLK_OUT(BITCLK_OUT),
  .BITCLK_OE(BITCLK_OE),
  .DATA_OE(DATA_OE),
  .CASCADE_N(CASCADE_N),
  .MEM_ADDR(MEM_ADDR),
  .SLAVE_MODE(SLAVE_MODE),
  .CONFIG_ERROR(CONFIG_ERROR),
  .CONFIG_DONE(CONFIG_DONE)
);

// ---- verification/cfg_loader_tb_top.sv ----
// Self-checking bench with reference outcome per scenario
`timescale 1ns/1ns
module cfg_loader_tb_top
  import cfg_loader_pkg::*;
;
  localparam int B = 32;
  logic clk = 0;
  logic rst = 1;
  logic bclk = 0;
  logic slv = 0;
  logic auto = 0;
  logic [B-1:0] mem = '0;
  logic [ADDR_W-1:0] addr;
  logic cs, pull, st, bo, boe, d, doe, stoe, slave, err, done, mbit, casc;
  int mode = 0;
  int bad_count = 0;
  int samples_checked = 0;
  int cyc = 0;
  // Open-drain status wire with its pull-up
  assign st = !(stoe || pull);
  assign mbit = mem[addr[4:0]];
  // Slave bit clock runs only in slave scenarios, unrelated phase
  always #5 clk = !clk;
  initial #3 forever #40 bclk = slv && !bclk;
  ////////////////////////////////////////
  cfg_loader #(.POR_COUNT(20), .BITS(B), .DONE_WAIT(DONE_WAIT_CLOCKS)) i_cfg_loader
  (
    .CLOCK(clk),
    .RST(rst),
    .CHIP_SEL_N(cs),
    .TARGET_STATUS_LOW_IN(st),
    .TARGET_STATUS_LOW_OUT(),
    .TARGET_STATUS_LOW_OE(stoe),
    .BITCLK_IN(bclk),
    .BITCLK_OUT(bo),
    .BITCLK_OE(boe),
    .DATA_OUT(d),
    .DATA_OE(doe),
    .CASCADE_N(casc),
    .AUTO_RESTART(auto),
    .MEM_BIT(mbit),
    .MEM_ADDR(addr),
    .SLAVE_MODE(slave),
    .CONFIG_ERROR(err),
    .CONFIG_DONE(done)
  );
  cfg_target_model #(.BITS(B)) i_cfg_target_model
  (
    .clk(clk),
    .rst(rst),
    .bitclk(bo && boe),
    .data(d),
    .data_oe(doe),
    .status(st),
    .mode(mode),
    .done_n(cs),
    .pull(pull)
  );
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task give_verdict;
    if (bad_count == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // Hang guard, far above ten scenarios
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      bad_count++;
      give_verdict;
    end
  end
  // Every target behaviour, without and then with auto-restart
  initial
  begin
    void'($urandom(49287));
    for (int i = 0; i < 10; i++)
    begin
      rst = 1;
      mode = i % 5;
      auto = i > 4;
      slv = mode == 4;
      mem = $urandom;
      repeat (16) @(negedge clk);
      rst = 0;
      for (int k = 0; k < 3000 && done !== 1 && slave !== 1 && !(err === 1 && !auto); k++)
        @(negedge clk);
      repeat (40) @(negedge clk);
      chk(slave, mode == 4);
      chk(err, !auto && (mode == 1 || mode == 2));
      chk(done, mode == 0 || mode == 3 || auto && mode != 4);
      chk(casc, !(mode == 0 || mode == 3 || auto && mode != 4));
      if (done === 1)
      begin
        chk(bo, 1'b0);
        chk(i_cfg_target_model.q.size(), B);
        for (int j = 0; j < B; j++)
          chk(i_cfg_target_model.q[j], mem[j]);
      end
    end
    give_verdict;
  end
endmodule

// ---- verification/cfg_target_model.sv ----
// Behavioural target device on the far side of the loader
`timescale 1ns/1ns
module cfg_target_model
#(
  parameter int BITS = 32
)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic bitclk,
  input wire logic data,
  input wire logic data_oe,
  input wire logic status,
  input wire integer mode,
  output logic done_n = 1'b1,
  output logic pull = 1'b0
);
  logic q[$];
  logic bc_q = 1'b0;
  int k = 0;
  int p = 0;
  bit f = 0;
  // Mode 0 good, 1 early done, 2 no done, 3 bad check, 4 slave (done held high)
  always @(negedge clk)
  begin
    if (rst)
      f = 0;
    else if (!status && k > 0)
      f = 1;
    if (rst || !status)
    begin
      k = 0;
      q.delete();
    end
    else if (bitclk && !bc_q)
    begin
      k = k + 1;
      if (data_oe)
        q.push_back(data);
    end
    bc_q = bitclk;
    if (mode == 3 && !f && k == 9)
      p = 6;
    pull = p > 0;
    if (p > 0)
      p = p - 1;
    // Once a failure was reported the next pass behaves
    done_n = mode == 4 || !f && mode == 1 && k >= 5 ||
      (f || mode == 0 || mode == 3) && k >= BITS + 3;
  end
endmodule
